/* logic/tracking_position_output_port.sv */
/*
  Digital output section of a tracking position converter: step counter, busy pulses,
  output latches with hold, byte-selectable three-state port, revolution carry and direction,
  plus an APB slave for status, latch readback and counter preset.
  Assumes step_req pulses come from the tracking loop and host pins are synchronous to mclk.
*/
// What this block does
// - Position latches stable soon after hold low
// - One busy pulse per one-LSB counter step
// - Hold freezes latches only; counter keeps running
// - Releasing hold launches one refreshing busy pulse
// - Disabled port floats; enabled port drives latches
// - Enable and byte select never touch counter
// - Low byte always on lower data lines
// - Upper lines: high byte or duplicated low byte
// - Bits unused at lower resolution read low
// - Major carry raises revolution carry output
// - Revolution carry lasts at least 300 ns
// - Carry rises before busy, clears before next unless direction changed
// - Direction change holds carry two busy edges
// - Direction changes before its busy and carry
// - Direction may toggle between steps; tolerate it
// - Carry and direction ignore the hold
`timescale 1ns/1ns
`include "tpo_defs.svh"
module tracking_position_output_port
  import tpo_pkg::*;
#(
  parameter int BUSY_CYCLES = `TPO_BUSY_CYCLES,
  parameter int CARRY_CYCLES = `TPO_CARRY_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tracking loop steps
  input wire logic step_req,
  input wire logic step_dir_up,
  // Host control pins
  input wire logic latch_hold_n,
  input wire logic out_enable_n,
  input wire logic byte_select_hi,
  input wire logic resolution_select_0,
  input wire logic resolution_select_1,
  // Status pins and data port
  output logic busy,
  output logic revolution_carry_out,
  output logic rotation_up,
  output data_port_t data_port
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  function automatic logic [15:0] lsb_weight(input res_sel_t r);
    lsb_weight = 16'h0001 << (`TPO_LSB_BASE_SHIFT - {r, 1'b0});
  endfunction

  function automatic logic [15:0] pos_mask(input res_sel_t r);
    pos_mask = ~(lsb_weight(r) - 16'h0001);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `TPO_OFF_STATUS) || (a == `TPO_OFF_LATCH) || (a == `TPO_OFF_PRESET);
  endfunction

  res_sel_t res;
  state_t state_reg;
  op_t op_reg;
  logic step_up_reg;
  logic step_pend_reg;
  logic pend_up_reg;
  logic preset_pend_reg;
  logic refresh_pend_reg;
  logic hold_n_prev_reg;
  logic [15:0] preset_val_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] latch_reg;
  logic [7:0] carry_cnt_reg;
  logic [1:0] sense_stable_reg;
  logic idle;
  logic take_step;
  logic take_preset;
  logic take_refresh;
  logic busy_start;
  logic wrap;
  logic bus_write;
  logic dir_change;
  status_t status;

  assign res = {resolution_select_1, resolution_select_0};
  assign idle = (state_reg == ST_IDLE);
  assign take_step = idle && step_pend_reg;
  assign take_preset = idle && !step_pend_reg && preset_pend_reg;
  assign take_refresh = idle && !step_pend_reg && !preset_pend_reg && refresh_pend_reg;
  assign busy_start = (state_reg == ST_ARM);
  assign wrap = step_up_reg ? (count_reg == pos_mask(res)) : (count_reg == 16'h0000);
  assign bus_write = psel && penable && pready && pwrite;
  assign dir_change = step_req && (step_dir_up != rotation_up);

  // Step requests wait here; direction is shown as soon as a step is requested
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      step_pend_reg <= 1'b0;
      pend_up_reg <= 1'b1;
      rotation_up <= 1'b1;
    end else begin
      if (step_req) begin
        pend_up_reg <= step_dir_up;
        rotation_up <= step_dir_up;
      end
      step_pend_reg <= step_req || (step_pend_reg && !take_step);
    end
  end

  // Hold release queues one refresh; a new release wins over the take
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_n_prev_reg <= 1'b1;
      refresh_pend_reg <= 1'b0;
    end else begin
      hold_n_prev_reg <= latch_hold_n;
      refresh_pend_reg <= (latch_hold_n && !hold_n_prev_reg) || (refresh_pend_reg && !take_refresh);
    end
  end

  // Sequencer: direction settles, then carry, then busy with the data update
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_REFRESH;
      step_up_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take_step) begin
            op_reg <= OP_STEP;
            step_up_reg <= pend_up_reg;
            state_reg <= ST_LEAD;
          end else if (take_preset) begin
            op_reg <= OP_PRESET;
            state_reg <= ST_LEAD;
          end else if (take_refresh) begin
            op_reg <= OP_REFRESH;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          state_reg <= ST_ARM;
        end
        ST_ARM: begin
          state_reg <= ST_BUSY;
        end
        ST_BUSY: begin
          if (!busy) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  pulse_timer #(
    .CYCLES(BUSY_CYCLES)
  ) u_busy (
    .mclk(mclk),
    .resetn(resetn),
    .start(busy_start),
    .pulse_reg(busy)
  );

  // Counter value taken at the busy edge, always masked to the resolution
  always_comb begin
    unique case (op_reg)
      OP_STEP: count_next = (step_up_reg ? count_reg + lsb_weight(res) : count_reg - lsb_weight(res)) & pos_mask(res);
      OP_PRESET: count_next = preset_val_reg & pos_mask(res);
      default: count_next = count_reg & pos_mask(res);
    endcase
  end

  // Counter runs regardless of hold, enable or byte select
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= `TPO_POS_RESET;
    end else if (busy_start) begin
      count_reg <= count_next;
    end
  end

  // Latches copy the counter on each busy pulse unless held
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= `TPO_POS_RESET;
    end else if (busy_start && latch_hold_n) begin
      latch_reg <= count_next;
    end
  end

  // Revolution carry: set ahead of busy, held for its minimum width and sense stability
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      revolution_carry_out <= 1'b0;
      carry_cnt_reg <= 8'h00;
      sense_stable_reg <= `TPO_SENSE_EDGES;
    end else if (state_reg == ST_LEAD && op_reg == OP_STEP && wrap) begin
      revolution_carry_out <= 1'b1;
      carry_cnt_reg <= 8'h00;
      sense_stable_reg <= dir_change ? 2'h0 : `TPO_SENSE_EDGES;
    end else if (revolution_carry_out) begin
      if (carry_cnt_reg != 8'hFF) begin
        carry_cnt_reg <= carry_cnt_reg + 8'h01;
      end
      if (dir_change) begin
        sense_stable_reg <= 2'h0;
      end else if (busy_start && sense_stable_reg != `TPO_SENSE_EDGES) begin
        sense_stable_reg <= sense_stable_reg + 2'h1;
      end
      if (carry_cnt_reg >= 8'(CARRY_CYCLES - 1) && sense_stable_reg == `TPO_SENSE_EDGES) begin
        revolution_carry_out <= 1'b0;
      end
    end
  end

  data_port_mux u_port (
    .mclk(mclk),
    .resetn(resetn),
    .latch_val(latch_reg),
    .byte_select_hi(byte_select_hi),
    .out_enable_n(out_enable_n),
    .port_reg(data_port)
  );

  always_comb begin
    status.zero = 12'h000;
    status.hold = !latch_hold_n;
    status.busy = busy;
    status.carry = revolution_carry_out;
    status.up = rotation_up;
    status.count = count_reg;
  end

  // APB: answer prepared in the setup cycle, ready on the first access cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !is_mapped(paddr);
      if (pwrite || !is_mapped(paddr)) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == `TPO_OFF_STATUS) begin
        prdata <= status;
      end else if (paddr == `TPO_OFF_LATCH) begin
        prdata <= {16'h0000, latch_reg};
      end else begin
        prdata <= {16'h0000, preset_val_reg};
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Preset write loads the counter through a normal busy cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preset_val_reg <= `TPO_POS_RESET;
      preset_pend_reg <= 1'b0;
    end else begin
      if (bus_write && paddr == `TPO_OFF_PRESET) begin
        preset_val_reg <= pwdata[15:0];
      end
      preset_pend_reg <= (bus_write && paddr == `TPO_OFF_PRESET) || (preset_pend_reg && !take_preset);
    end
  end

  property p_hold_stable;
    !latch_hold_n && $past(!latch_hold_n) |-> $stable(latch_reg);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("Latches moved while held");

  property p_step_busy;
    (state_reg == ST_LEAD && op_reg == OP_STEP) |-> ##2 $rose(busy) ##1 busy ##1 !busy;
  endproperty
  a_step_busy: assert property (p_step_busy) else $error("Step did not give one busy pulse");

  property p_step_count;
    $rose(busy) && op_reg == OP_STEP |-> count_reg != $past(count_reg);
  endproperty
  a_step_count: assert property (p_step_count) else $error("Busy pulse without counter step");

  property p_hold_counts;
    $rose(busy) && op_reg == OP_STEP && $past(!latch_hold_n) |-> $stable(latch_reg) && count_reg != $past(count_reg);
  endproperty
  a_hold_counts: assert property (p_hold_counts) else $error("Hold stopped counter or moved latch");

  property p_release_busy;
    $rose(latch_hold_n) |-> ##[1:24] $rose(busy);
  endproperty
  a_release_busy: assert property (p_release_busy) else $error("No busy pulse after hold release");

  property p_follow;
    $rose(busy) && $past(latch_hold_n) |-> latch_reg == count_reg;
  endproperty
  a_follow: assert property (p_follow) else $error("Latch did not follow counter");

  property p_low_bits;
    $rose(busy) |-> (count_reg & ~pos_mask($past(res))) == 16'h0000;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("Unused low position bits not zero");

  property p_carry_wrap;
    $rose(revolution_carry_out) |=> $rose(busy) && (step_up_reg ? count_reg == 16'h0000 : count_reg == pos_mask(res));
  endproperty
  a_carry_wrap: assert property (p_carry_wrap) else $error("Carry without major carry or busy");

  property p_carry_width;
    $rose(revolution_carry_out) |-> revolution_carry_out[*3];
  endproperty
  a_carry_width: assert property (p_carry_width) else $error("Revolution carry too short");

  property p_carry_sense;
    revolution_carry_out && sense_stable_reg != `TPO_SENSE_EDGES |=> revolution_carry_out;
  endproperty
  a_carry_sense: assert property (p_carry_sense) else $error("Carry cleared before sense stable");

  property p_dir_leads;
    step_req |=> rotation_up == $past(step_dir_up) && !$rose(busy) ##1 !$rose(revolution_carry_out);
  endproperty
  a_dir_leads: assert property (p_dir_leads) else $error("Direction not ahead of busy and carry");

  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready not a single access cycle");

endmodule

/* logic/tpo_defs.svh */
/*
  Constants for the tracking position output port: bus offsets, reset values and timing counts.
  Assumes a 10 MHz mclk; every cycle count is derived from its time in nanoseconds.
*/
`ifndef TPO_DEFS_SVH
`define TPO_DEFS_SVH

`define TPO_CLK_PERIOD_NS 100
`define TPO_BUSY_WIDTH_NS 200
`define TPO_BUSY_CYCLES ((`TPO_BUSY_WIDTH_NS + `TPO_CLK_PERIOD_NS - 1) / `TPO_CLK_PERIOD_NS)
`define TPO_CARRY_MIN_NS 300
`define TPO_CARRY_CYCLES ((`TPO_CARRY_MIN_NS + `TPO_CLK_PERIOD_NS - 1) / `TPO_CLK_PERIOD_NS)
`define TPO_HOLD_VALID_NS 600
`define TPO_HOLD_VALID_CYCLES (`TPO_HOLD_VALID_NS / `TPO_CLK_PERIOD_NS)
`define TPO_SENSE_EDGES 2'h2

`define TPO_OFF_STATUS 12'h000
`define TPO_OFF_LATCH 12'h004
`define TPO_OFF_PRESET 12'h008

`define TPO_POS_RESET 16'h0000
`define TPO_LSB_BASE_SHIFT 3'h6

`endif

/* logic/tpo_pkg.sv */
/*
  Types shared by the tracking position output port and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tpo_pkg;

  typedef logic [1:0] res_sel_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_ARM, ST_BUSY} state_t;

  typedef enum logic [1:0] {OP_STEP, OP_PRESET, OP_REFRESH} op_t;

  typedef struct packed {
    logic [11:0] zero;
    logic hold;
    logic busy;
    logic carry;
    logic up;
    logic [15:0] count;
  } status_t;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } data_port_t;

endpackage

/* logic/pulse_timer.sv */
/*
  One-shot pulse of a fixed number of clock cycles, output straight from a flip-flop.
  Assumes start is a one-cycle request that does not arrive while the pulse is high.
*/
`timescale 1ns/1ns
module pulse_timer #(
  parameter int CYCLES = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Request and pulse
  input wire logic start,
  output logic pulse_reg
);

  logic [7:0] left_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pulse_reg <= 1'b0;
      left_reg <= 8'h00;
    end else if (start) begin
      pulse_reg <= 1'b1;
      left_reg <= 8'(CYCLES - 1);
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end else begin
      pulse_reg <= 1'b0;
    end
  end

endmodule

/* logic/data_port_mux.sv */
/*
  Three-state byte-selectable data port stage, registered.
  Assumes latch_val is already masked to the selected resolution.
*/
`timescale 1ns/1ns
module data_port_mux
  import tpo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Position and host selects
  input wire logic [15:0] latch_val,
  input wire logic byte_select_hi,
  input wire logic out_enable_n,
  // Pins
  output data_port_t port_reg
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Only the pins react to the selects; nothing feeds back into the counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      port_reg.data <= 16'h0000;
      port_reg.oe_n <= 16'hFFFF;
    end else begin
      port_reg.oe_n <= {16{out_enable_n}};
      port_reg.data[7:0] <= out_enable_n ? 8'h00 : latch_val[7:0];
      if (out_enable_n) begin
        port_reg.data[15:8] <= 8'h00;
      end else begin
        port_reg.data[15:8] <= byte_select_hi ? latch_val[15:8] : latch_val[7:0];
      end
    end
  end

  property p_hiz;
    out_enable_n |=> (port_reg.oe_n == 16'hFFFF);
  endproperty
  a_hiz: assert property (p_hiz) else $error("Data port driven while disabled");

  property p_lsb_low;
    !out_enable_n |=> (port_reg.oe_n == 16'h0000) && (port_reg.data[7:0] == $past(latch_val[7:0]));
  endproperty
  a_lsb_low: assert property (p_lsb_low) else $error("Low byte lines do not show position low byte");

  property p_upper;
    !out_enable_n && byte_select_hi |=> port_reg.data[15:8] == $past(latch_val[15:8]);
  endproperty
  a_upper: assert property (p_upper) else $error("Upper lines do not show high byte");

  property p_dup;
    !out_enable_n && !byte_select_hi |=> port_reg.data[15:8] == port_reg.data[7:0];
  endproperty
  a_dup: assert property (p_dup) else $error("Upper lines do not duplicate low byte");

endmodule

/* tb/rev_counter_model.sv */
/*
  External revolution counter fed by the carry and direction outputs.
  Assumes both outputs are synchronous to mclk.
*/
`timescale 1ns/1ns
module rev_counter_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Device outputs
  input wire logic revolution_carry_out,
  input wire logic rotation_up,
  // Revolution tally
  output int revs
);
  logic carry_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      carry_q <= 1'h0;
      revs <= 0;
    end else begin
      carry_q <= revolution_carry_out;
      // Direction is read only at the carry edge, so toggles between steps do no harm
      if (revolution_carry_out && !carry_q) begin
        revs <= rotation_up ? revs + 1 : revs - 1;
      end
    end
  end
endmodule

/* tb/tracking_position_output_port_bench.sv */
/*
  Self-checking bench: APB master, host pin driver and reference model of the position port.
  Assumes the design package and defines header are compiled first.
*/
`timescale 1ns/1ns
`include "tpo_defs.svh"
module tracking_position_output_port_bench
  import tpo_pkg::*;
();
  localparam int CARRY_N = 3;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, busy, revolution_carry_out, rotation_up, err;
  logic step_req = 1'h0, step_dir_up = 1'h0, latch_hold_n = 1'h1, out_enable_n = 1'h1;
  logic byte_select_hi = 1'h0, resolution_select_0 = 1'h1, resolution_select_1 = 1'h1;
  logic busy_q = 1'h0, carry_q = 1'h0;
  data_port_t data_port;
  int bad_count = 0, checks_done = 0, cycles = 0, revs, busy_rises = 0, carry_len = 0;
  int m_count = 0, m_latch = 0, m_busy = 0, m_revs = 0, m_step = 1, m_held = 0;

  initial begin
    forever #50 mclk = ~mclk;
  end

  tracking_position_output_port #(.BUSY_CYCLES(2), .CARRY_CYCLES(CARRY_N)) DUT (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_req(step_req), .step_dir_up(step_dir_up), .latch_hold_n(latch_hold_n),
    .out_enable_n(out_enable_n), .byte_select_hi(byte_select_hi),
    .resolution_select_0(resolution_select_0), .resolution_select_1(resolution_select_1),
    .busy(busy), .revolution_carry_out(revolution_carry_out), .rotation_up(rotation_up),
    .data_port(data_port)
  );

  rev_counter_model partner (
    .mclk(mclk), .resetn(resetn), .revolution_carry_out(revolution_carry_out),
    .rotation_up(rotation_up), .revs(revs)
  );

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Pulse edges, carry width and the hang limit
  always @(posedge mclk) begin
    busy_q <= busy;
    carry_q <= revolution_carry_out;
    carry_len <= (revolution_carry_out === 1'h1) ? carry_len + 1 : 0;
    cycles <= cycles + 1;
    if (busy === 1'h1 && busy_q === 1'h0) busy_rises <= busy_rises + 1;
    if (revolution_carry_out === 1'h1 && carry_q === 1'h0) chk("busy at carry rise", 32'h0, {31'h0, busy});
    if (revolution_carry_out === 1'h0 && carry_q === 1'h1) chk("carry width", 32'h1, {31'h0, carry_len >= CARRY_N});
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // One APB transfer; waits for pready whatever the latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Let an edge pass so a following call never drives psel twice in one step
    @(posedge mclk);
  endtask

  task automatic port(input logic en_n, input logic hi);
    int e;
    out_enable_n <= en_n;
    byte_select_hi <= hi;
    repeat (2) @(posedge mclk);
    e = ((((hi ? m_latch >> 8 : m_latch) & 32'hFF) << 8) | (m_latch & 32'hFF));
    chk("port enables", en_n ? 32'hFFFF : 32'h0, {16'h0, data_port.oe_n});
    if (!en_n) chk("port data", e, {16'h0, data_port.data});
  endtask

  task automatic step(input logic up);
    int wrap;
    wrap = up ? (m_count == (32'hFFFF & ~(m_step - 1))) : (m_count == 0);
    step_req <= 1'h1;
    step_dir_up <= up;
    @(posedge mclk);
    step_req <= 1'h0;
    m_count = (m_count + (up ? m_step : -m_step)) & 32'hFFFF;
    m_busy++;
    if (!m_held) m_latch = m_count;
    if (wrap) m_revs += up ? 1 : -1;
    repeat (7) @(posedge mclk);
    chk("rotation_up", {31'h0, up}, {31'h0, rotation_up});
    chk("busy pulses", m_busy, busy_rises);
    chk("revolutions", m_revs, revs);
  endtask

  task automatic preset(input int v);
    apb(1'h1, `TPO_OFF_PRESET, v);
    m_count = v & 32'hFFFF & ~(m_step - 1);
    m_busy++;
    m_latch = m_count;
    repeat (8) @(posedge mclk);
  endtask

  task automatic check_all();
    apb(1'h0, `TPO_OFF_STATUS, 32'h0);
    chk("counter", m_count, {16'h0, rd[15:0]});
    apb(1'h0, `TPO_OFF_LATCH, 32'h0);
    chk("latch", m_latch, rd);
    port(1'h0, 1'h1);
    port(1'h0, 1'h0);
    port(1'h1, 1'h0);
  endtask

  initial begin
    void'($urandom(32'h6996));
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    port(1'h1, 1'h0);
    apb(1'h0, `TPO_OFF_STATUS, 32'h0);
    chk("status after reset", 32'h0001_0000, rd);
    apb(1'h1, 12'h00C, 32'h0000_1234);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'h1, `TPO_OFF_STATUS, 32'h0000_FFFF);
    for (int r = 0; r < 4; r++) begin
      resolution_select_1 <= r[1];
      resolution_select_0 <= r[0];
      m_step = 1 << (6 - 2 * r);
      @(posedge mclk);
      preset($urandom);
      repeat (4) step($urandom_range(1, 0));
      check_all();
      preset(32'hFFFF);
      step(1'h1);
      step(1'h0);
      check_all();
    end
    // Direction flips twice while the carry is high; the two requests merge into one step up
    preset(32'hFFFF);
    step_req <= 1'h1;
    step_dir_up <= 1'h1;
    @(posedge mclk);
    step_req <= 1'h0;
    repeat (3) @(posedge mclk);
    step_req <= 1'h1;
    step_dir_up <= 1'h0;
    @(posedge mclk);
    step_dir_up <= 1'h1;
    @(posedge mclk);
    step_req <= 1'h0;
    m_count = m_step;
    m_latch = m_count;
    m_busy += 2;
    m_revs++;
    repeat (6) @(posedge mclk);
    chk("carry held after flip", 32'h1, {31'h0, revolution_carry_out});
    chk("merged busy pulses", m_busy, busy_rises);
    chk("revolutions after flip", m_revs, revs);
    step(1'h1);
    chk("carry cleared after stable", 32'h0, {31'h0, revolution_carry_out});
    // Freeze the latches, move the counter, then release
    latch_hold_n <= 1'h0;
    m_held = 1;
    repeat (6) @(posedge mclk);
    step(1'h1);
    step(1'h1);
    check_all();
    latch_hold_n <= 1'h1;
    m_held = 0;
    m_latch = m_count;
    m_busy++;
    repeat (8) @(posedge mclk);
    chk("refresh pulses", m_busy, busy_rises);
    check_all();
    report_and_stop();
  end
endmodule
